// ### logic/packetizer_consts.vh
// Constants shared by the serial datagram packetizer: offsets, fields, resets, limits
`ifndef PACKETIZER_CONSTS_VH
`define PACKETIZER_CONSTS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_START1 8'h04
`define OFS_START2 8'h08
`define OFS_END1 8'h0c
`define OFS_END2 8'h10
`define OFS_EXTRA 8'h14
`define OFS_MTU 8'h18
`define OFS_STATUS 8'h1c
`define OFS_DGCOUNT 8'h20

// Control fields
`define CTRL_FRAME_BIT 0
`define CTRL_FIFO_BIT 1
`define CTRL_RESET 2'h0

// Sequence register layout: bytes in arrival order, size in the top field
`define SEQ_WIDTH 26
`define SEQ_SIZE_LSB 24
`define SEQ_SIZE_MSB 25
`define SEQ_RESET 26'h0000000

// Trailing byte count
`define EXTRA_WIDTH 10
`define EXTRA_RESET 10'h000

// Maximum packet size limits
`define MTU_WIDTH 11
`define MTU_RESET 11'h230
`define MTU_MAX 11'h400
`define MTU_MIN 11'h004

// Status fields
`define STATUS_STATE_LSB 0
`define STATUS_COUNT_LSB 16

// Datagram buffer and receive FIFO shape
`define BUF_DEPTH 1024
`define BUF_AW 10
`define RXF_WIDTH 8
`define RXF_DEPTH 4
`define RXF_AW 2

`endif

// ### logic/rx_byte_fifo.v
// Small receive FIFO with optional single-entry mode for low latency
module rx_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire shallow,
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output reg in_ready,
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    reg [AW:0] next_count;

    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];

    // Occupancy after this cycle's push and pop
    always @* begin
        next_count = count;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    // Ready is registered so the source sees a clean flop; shallow mode holds one byte
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= next_count;
            if (shallow)
                in_ready <= (next_count == {(AW+1){1'b0}});
            else
                in_ready <= (next_count < DEPTH[AW:0]);
        end
    end

    // Storage needs no reset
    always @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

// ### logic/serial_datagram_packetizer.v
// Receive-side packetizer: frames serial bytes into network datagrams
//
// Overview of operation
// - With framing on, a datagram is released once a start and a matching end sequence arrived.
// - With both start sizes zero, an end sequence alone releases the datagram.
// - Two independent start sequences exist, each up to three bytes long.
// - A start size of zero turns matching of that start sequence off.
// - Two independent end sequences of up to three bytes exist and either one closes.
// - After an end match the configured number of extra bytes is still collected unless the size limit is reached first.
// - After a start match the following bytes are gathered until an end sequence arrives.
// - Gathered data leave as soon as the maximum size (reset 560, at most 1024) is reached.
// - With framing off every received byte is forwarded at once.
// - Start and end framing acts only on datagrams begun while its enable bit is set.
// - The receive FIFO can be switched on, or off to a single entry for least delay.
`include "packetizer_consts.vh"

module serial_datagram_packetizer (
    input wire clk,
    input wire rst_n,
    input wire rx_valid,
    input wire [7:0] rx_data,
    output wire rx_ready,
    output reg pkt_valid,
    output reg [7:0] pkt_data,
    output reg pkt_last,
    input wire pkt_ready,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata
);
    // Framing states; the code is visible to software in the status word
    localparam S_SEEK = 3'd0;
    localparam S_PRE = 3'd1;
    localparam S_COL = 3'd2;
    localparam S_EXT = 3'd3;
    localparam S_SEND = 3'd4;

    // Settings written by software
    reg [1:0] ctrl;
    reg [`SEQ_WIDTH-1:0] start1;
    reg [`SEQ_WIDTH-1:0] start2;
    reg [`SEQ_WIDTH-1:0] end1;
    reg [`SEQ_WIDTH-1:0] end2;
    reg [`EXTRA_WIDTH-1:0] extra;
    reg [`MTU_WIDTH-1:0] mtu;

    // Framing engine state, match history and datagram buffer
    reg [2:0] state;
    reg [`MTU_WIDTH-1:0] cnt;
    reg [`MTU_WIDTH-1:0] rd_ptr;
    reg [`EXTRA_WIDTH-1:0] ext_left;
    reg [1:0] pre_n;
    reg [23:0] hist;
    reg [1:0] hc;
    reg [15:0] dgram_count;
    reg [7:0] mem [0:`BUF_DEPTH-1];
    reg [7:0] pre_byte;

    // Receive FIFO output side and the pull that drains it
    wire f_valid;
    wire intake;
    wire [7:0] f_data;
    wire frame_en = ctrl[`CTRL_FRAME_BIT];

    // FIFO off means one byte of slack only, trading throughput for delay
    rx_byte_fifo #(
        .WIDTH(`RXF_WIDTH),
        .DEPTH(`RXF_DEPTH),
        .AW(`RXF_AW)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .shallow(~ctrl[`CTRL_FIFO_BIT]),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .in_ready(rx_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(intake)
    );

    // Sequence match against newest history; byte 0 of a sequence arrives first
    // A size of zero never matches, which is how a sequence is switched off
    function seq_hit;
        input [`SEQ_WIDTH-1:0] s;
        input [23:0] h;
        input [1:0] n;
        begin
            case (s[`SEQ_SIZE_MSB:`SEQ_SIZE_LSB])
                2'd1: seq_hit = (n >= 2'd1) && (s[7:0] == h[7:0]);
                2'd2: seq_hit = (n >= 2'd2) && (s[7:0] == h[15:8]) && (s[15:8] == h[7:0]);
                2'd3: seq_hit = (n == 2'd3) && (s[7:0] == h[23:16]) &&
                    (s[15:8] == h[15:8]) && (s[23:16] == h[7:0]);
                default: seq_hit = 1'b0;
            endcase
        end
    endfunction

    // Start matching is off when both start sizes are zero
    wire start_off = (start1[`SEQ_SIZE_MSB:`SEQ_SIZE_LSB] == 2'd0) &&
        (start2[`SEQ_SIZE_MSB:`SEQ_SIZE_LSB] == 2'd0);

    // Intake opens only where a byte is stored or dropped; replay and send stall it
    assign intake = ((state == S_SEEK) && !(frame_en && start_off)) ||
        (state == S_COL) || (state == S_EXT);

    // Byte taken this cycle and the history it leaves, newest byte lowest
    wire take = f_valid && intake;
    wire [23:0] nh = {hist[15:0], f_data};
    wire [1:0] nhc = (hc == 2'd3) ? 2'd3 : hc + 2'd1;

    // Matches are judged on the history including this byte; start one wins a tie
    wire hit_s1 = seq_hit(start1, nh, nhc);
    wire hit_s2 = seq_hit(start2, nh, nhc);
    wire s_hit = hit_s1 || hit_s2;
    wire [1:0] s_len = hit_s1 ? start1[`SEQ_SIZE_MSB:`SEQ_SIZE_LSB] :
        start2[`SEQ_SIZE_MSB:`SEQ_SIZE_LSB];
    wire e_hit = seq_hit(end1, nh, nhc) || seq_hit(end2, nh, nhc);

    // The size check looks one byte ahead so the limit byte itself closes the datagram
    wire [`MTU_WIDTH-1:0] ncnt = cnt + 11'd1;
    wire at_mtu = (ncnt >= mtu);
    wire [`MTU_WIDTH-1:0] next_rd = rd_ptr + 11'd1;

    // Status word for software polling: engine state low, buffer fill above
    wire [31:0] status_word = ({29'h0, state} << `STATUS_STATE_LSB) |
        ({21'h0, cnt} << `STATUS_COUNT_LSB);

    // Matched start bytes are replayed from history, oldest first
    always @* begin
        case (pre_n)
            2'd3: pre_byte = hist[23:16];
            2'd2: pre_byte = hist[15:8];
            default: pre_byte = hist[7:0];
        endcase
    end

    // Datagram buffer writes: start prefix, then every taken byte in order
    always @(posedge clk) begin
        if (state == S_PRE)
            mem[cnt[`BUF_AW-1:0]] <= pre_byte;
        else if (take && (state != S_SEEK || !frame_en))
            mem[cnt[`BUF_AW-1:0]] <= f_data;
    end

    // Framing state machine and packet output
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_SEEK;
            cnt <= 11'h000;
            rd_ptr <= 11'h000;
            ext_left <= 10'h000;
            pre_n <= 2'h0;
            hist <= 24'h000000;
            hc <= 2'h0;
            dgram_count <= 16'h0000;
            pkt_valid <= 1'b0;
            pkt_data <= 8'h00;
            pkt_last <= 1'b0;
        end else begin
            case (state)
                // Hunt for a start sequence, or pass bytes straight through with framing off
                S_SEEK: begin
                    if (!frame_en) begin
                        // Stale history must not pair with bytes seen after framing returns
                        hist <= 24'h000000;
                        hc <= 2'h0;
                        if (take) begin
                            cnt <= 11'h001;
                            state <= S_SEND;
                        end
                    end else if (start_off) begin
                        state <= S_COL;
                    end else if (take) begin
                        hist <= nh;
                        hc <= nhc;
                        if (s_hit) begin
                            pre_n <= s_len;
                            cnt <= 11'h000;
                            state <= S_PRE;
                        end
                    end
                end

                // Replay the matched start bytes into the buffer, one per cycle
                S_PRE: begin
                    cnt <= ncnt;
                    pre_n <= pre_n - 2'd1;
                    if (pre_n == 2'd1)
                        state <= S_COL;
                end

                // Gather payload until an end sequence or the size limit
                S_COL: begin
                    if (take) begin
                        cnt <= ncnt;
                        hist <= nh;
                        hc <= nhc;
                        if ((e_hit && extra == 10'h000) || at_mtu) begin
                            state <= S_SEND;
                            hist <= 24'h000000;
                            hc <= 2'h0;
                        end else if (e_hit) begin
                            ext_left <= extra;
                            state <= S_EXT;
                        end
                    end
                end

                S_EXT: begin
                    // Trailing bytes are never checked against the end sequences
                    if (take) begin
                        cnt <= ncnt;
                        ext_left <= ext_left - 10'd1;
                        if (ext_left == 10'd1 || at_mtu) begin
                            state <= S_SEND;
                            hist <= 24'h000000;
                            hc <= 2'h0;
                        end
                    end
                end

                S_SEND: begin
                    // Intake stalls here, so back-pressure reaches the serial side
                    if (!pkt_valid || pkt_ready) begin
                        if (pkt_valid && pkt_last) begin
                            pkt_valid <= 1'b0;
                            pkt_last <= 1'b0;
                            cnt <= 11'h000;
                            rd_ptr <= 11'h000;
                            dgram_count <= dgram_count + 16'h0001;
                            state <= S_SEEK;
                        end else begin
                            pkt_data <= mem[rd_ptr[`BUF_AW-1:0]];
                            pkt_valid <= 1'b1;
                            pkt_last <= (next_rd == cnt);
                            rd_ptr <= next_rd;
                        end
                    end
                end
                default: state <= S_SEEK;
            endcase
        end
    end

    // Register writes; the size limit is clamped to its legal range
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `CTRL_RESET;
            start1 <= `SEQ_RESET;
            start2 <= `SEQ_RESET;
            end1 <= `SEQ_RESET;
            end2 <= `SEQ_RESET;
            extra <= `EXTRA_RESET;
            mtu <= `MTU_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_CTRL: ctrl <= reg_wdata[1:0];
                `OFS_START1: start1 <= reg_wdata[`SEQ_WIDTH-1:0];
                `OFS_START2: start2 <= reg_wdata[`SEQ_WIDTH-1:0];
                `OFS_END1: end1 <= reg_wdata[`SEQ_WIDTH-1:0];
                `OFS_END2: end2 <= reg_wdata[`SEQ_WIDTH-1:0];
                `OFS_EXTRA: extra <= reg_wdata[`EXTRA_WIDTH-1:0];
                `OFS_MTU: begin
                    // A floor of four leaves room for a full start sequence plus one byte
                    if (reg_wdata > {21'h000000, `MTU_MAX})
                        mtu <= `MTU_MAX;
                    else if (reg_wdata < {21'h000000, `MTU_MIN})
                        mtu <= `MTU_MIN;
                    else
                        mtu <= reg_wdata[`MTU_WIDTH-1:0];
                end
                default: ;
            endcase
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_CTRL: reg_rdata <= {30'h00000000, ctrl};
                `OFS_START1: reg_rdata <= {6'h00, start1};
                `OFS_START2: reg_rdata <= {6'h00, start2};
                `OFS_END1: reg_rdata <= {6'h00, end1};
                `OFS_END2: reg_rdata <= {6'h00, end2};
                `OFS_EXTRA: reg_rdata <= {22'h000000, extra};
                `OFS_MTU: reg_rdata <= {21'h000000, mtu};
                `OFS_STATUS: reg_rdata <= status_word;
                `OFS_DGCOUNT: reg_rdata <= {16'h0000, dgram_count};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// ### tb/packetizer_props.sv
// Port checker for the serial datagram packetizer
`include "packetizer_consts.vh"
module packetizer_props (
    input logic clk,
    input logic rst_n,
    input logic rx_valid,
    input logic [7:0] rx_data,
    input logic rx_ready,
    input logic pkt_valid,
    input logic [7:0] pkt_data,
    input logic pkt_last,
    input logic pkt_ready,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic frame_on, fifo_on;
    logic [10:0] mtu, beats;
    // Shadow of settings and of beats sent in the current datagram
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_on <= 1'b0;
            fifo_on <= 1'b0;
            mtu <= `MTU_RESET;
            beats <= 11'h000;
        end else begin
            if (reg_wr && reg_addr == `OFS_CTRL) begin
                frame_on <= reg_wdata[0];
                fifo_on <= reg_wdata[1];
            end
            if (reg_wr && reg_addr == `OFS_MTU)
                mtu <= reg_wdata > {21'h0, `MTU_MAX} ? `MTU_MAX :
                    (reg_wdata < {21'h0, `MTU_MIN} ? `MTU_MIN : reg_wdata[10:0]);
            if (pkt_valid && pkt_ready)
                beats <= pkt_last ? 11'h000 : beats + 11'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_rdata_quiet: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
        else $error("read data outside read slot");
    chk_pkt_stands: assert property (pkt_valid && !pkt_ready |=>
        pkt_valid && $stable(pkt_data) && $stable(pkt_last)) else $error("beat dropped");
    chk_dg_gap: assert property (pkt_valid && pkt_ready && pkt_last |=> !pkt_valid)
        else $error("no idle cycle after datagram");
    chk_plain_single: assert property (!frame_on && pkt_valid |-> pkt_last)
        else $error("unframed byte not alone");
    chk_mtu_flush: assert property (pkt_valid && beats == mtu - 11'h001 |-> pkt_last)
        else $error("datagram exceeds size limit");
    chk_shallow_fifo: assert property (!fifo_on && rx_valid && rx_ready |=> !rx_ready)
        else $error("single entry fifo took two");
    chk_mtu_read: assert property (reg_rd && reg_addr == `OFS_MTU |=>
        reg_rdata == {21'h0, mtu}) else $error("size limit reads wrong");
    chk_ctrl_read: assert property (reg_rd && reg_addr == `OFS_CTRL |=>
        reg_rdata[1:0] == {fifo_on, frame_on}) else $error("control reads wrong");
endmodule

bind serial_datagram_packetizer packetizer_props chk (.clk(clk), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .pkt_valid(pkt_valid),
    .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ### tb/serial_source.sv
// Serial terminal model: sends queued bytes, holding each until taken
module serial_source (
    input wire logic clk,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[$];
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // Idle line toggles so a stale byte is never mistaken for data
    always @(posedge clk) begin
        if (!rx_valid || rx_ready) begin
            if (q.size() != 0 && !(slow && rx_valid)) begin
                rx_valid <= 1'b1;
                rx_data <= q.pop_front();
            end else begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
            end
        end
    end
endmodule

// ### tb/test_serial_datagram_packetizer.sv
// Self-checking bench for the serial datagram packetizer
`include "packetizer_consts.vh"
module test_serial_datagram_packetizer;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pkt_ready = 1'b0;
    logic stall = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic rx_valid, rx_ready, pkt_valid, pkt_last;
    logic [7:0] rx_data, pkt_data;
    logic [31:0] reg_rdata;
    logic [8:0] outq[$];
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    serial_source src (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
    serial_datagram_packetizer DUT (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_last(pkt_last), .pkt_ready(pkt_ready), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // 50 ns period
    always #25 clk = ~clk;
    // Network side: takes every beat, or every other cycle while stalling
    always @(posedge clk) begin
        pkt_ready <= stall ? ~pkt_ready : 1'b1;
        if (pkt_valid && pkt_ready)
            outq.push_back({pkt_last, pkt_data});
    end
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_byte(input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t beat %h expected %h", $time, g, e);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_expect(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check_word(e, reg_rdata);
    endtask
    // Sends s; bytes from skip on must come back as one datagram, or singly if each
    task automatic send_dg(input logic [7:0] s[$], input int skip, input bit each);
        int k;
        k = 0;
        foreach (s[i]) src.q.push_back(s[i]);
        while (outq.size() < s.size() - skip && k < 2000) begin
            @(posedge clk);
            k++;
        end
        repeat (6) @(posedge clk);
        for (int i = skip; i < s.size(); i++)
            check_byte({each || i == s.size() - 1, s[i]}, outq.pop_front());
        check_word(32'h0, 32'(outq.size()));
    endtask
    task automatic test_reset();
        reg_expect(`OFS_CTRL, 32'h0);
        reg_expect(`OFS_MTU, 32'h230);
        reg_expect(`OFS_START1, 32'h0);
        reg_expect(`OFS_EXTRA, 32'h0);
        reg_expect(8'h40, 32'h0);
        $display("reset values done");
    endtask
    task automatic test_plain();
        src.slow = 1'b1;
        send_dg('{8'ha1, 8'h3a, 8'h0d}, 0, 1);
        reg_write(`OFS_CTRL, 32'h2);
        reg_expect(`OFS_CTRL, 32'h2);
        src.slow = 1'b0;
        stall = 1'b1;
        send_dg('{8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7}, 0, 1);
        stall = 1'b0;
        $display("unframed done");
    endtask
    task automatic test_start_end();
        reg_write(`OFS_START1, 32'h0100003a);
        reg_write(`OFS_END1, 32'h02000a0d);
        reg_write(`OFS_CTRL, 32'h3);
        send_dg('{8'h0d, 8'h0a, 8'h3a, 8'h41, 8'h0d, 8'h0a}, 2, 0);
        send_dg('{8'h3a, 8'h42, 8'h0d, 8'h0a}, 0, 0);
        $display("start end done");
    endtask
    task automatic test_second_start();
        reg_write(`OFS_START2, 32'h02000302);
        reg_write(`OFS_END2, 32'h01000004);
        reg_write(`OFS_START1, 32'h0);
        send_dg('{8'h55, 8'h02, 8'h03, 8'h56, 8'h04}, 1, 0);
        send_dg('{8'h3a, 8'h02, 8'h03, 8'h57, 8'h0d, 8'h0a}, 1, 0);
        $display("second start done");
    endtask
    task automatic test_end_only();
        reg_write(`OFS_START2, 32'h0);
        reg_write(`OFS_END1, 32'h01000003);
        reg_write(`OFS_END2, 32'h02000d0a);
        reg_write(`OFS_EXTRA, 32'h2);
        send_dg('{8'h11, 8'h03, 8'haa, 8'hbb}, 0, 0);
        reg_write(`OFS_EXTRA, 32'h0);
        send_dg('{8'h22, 8'h0a, 8'h0d}, 0, 0);
        $display("end only done");
    endtask
    task automatic test_mtu();
        reg_write(`OFS_MTU, 32'h2);
        reg_expect(`OFS_MTU, 32'h4);
        send_dg('{8'h61, 8'h62, 8'h63, 8'h64}, 0, 0);
        send_dg('{8'h65, 8'h66, 8'h03}, 0, 0);
        reg_write(`OFS_MTU, 32'h7ff);
        reg_expect(`OFS_MTU, 32'h400);
        reg_expect(`OFS_STATUS, 32'h2);
        reg_expect(`OFS_DGCOUNT, 32'h12);
        $display("size limit done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_plain();
        test_start_end();
        test_second_start();
        test_end_only();
        test_mtu();
        print_verdict();
    end
endmodule
